// ---- clk_ratio_pkg.sv ----
// constants, types and register map shared by the clock ratio control block
package clk_ratio_pkg;

    localparam int CLK_HZ = 20_000_000;

    // register byte offsets on the bus
    localparam logic [3:0] OFF_RATIO = 4'h0;
    localparam logic [3:0] OFF_WDSETUP = 4'h4;
    localparam logic [3:0] OFF_STATUS = 4'h8;

    // clock_ratio_control fields
    localparam int BIT_PLL2_BYP = 7;
    localparam int BIT_PLL1_BYP = 6;
    localparam int BIT_TRIS = 5;
    localparam int BIT_RSVD = 4;
    localparam int FR_MSB = 3;
    localparam int FR_LSB = 0;

    // reset values per clock mode
    localparam logic [7:0] RST_MODE01 = 8'h00;
    localparam logic [7:0] RST_MODE2 = 8'h40;
    localparam logic [7:0] RST_MODE3 = 8'h60;
    localparam logic [7:0] RST_MODE45 = 8'hA6;
    localparam logic [7:0] RST_MODE6 = 8'hE0;

    // watchdog_ctrl_status shadow fields
    localparam int WD_CKS_LSB = 0;
    localparam int WD_CKS_W = 3;
    localparam int WD_TMODE_BIT = 5;
    localparam int WD_EN_BIT = 7;
    localparam logic [7:0] WD_SETUP_RST = 8'h00;

    // whole-device halt after a ratio write, in peripheral clock cycles
    localparam int HALT_PCLK_CYCLES = 5;
    localparam logic [2:0] HALT_CYCLES = 3'(HALT_PCLK_CYCLES);

    localparam int SETTLE_CNT_W = 8;
    localparam logic [SETTLE_CNT_W-1:0] SETTLE_CNT_MAX = 8'hFF;

    localparam logic [2:0] MODE0 = 3'h0;
    localparam logic [2:0] MODE1 = 3'h1;
    localparam logic [2:0] MODE2 = 3'h2;
    localparam logic [2:0] MODE3 = 3'h3;
    localparam logic [2:0] MODE4 = 3'h4;
    localparam logic [2:0] MODE5 = 3'h5;
    localparam logic [2:0] MODE6 = 3'h6;

    typedef enum logic [2:0] {
        R_QUARTER = 3'b000,
        R_HALF = 3'b001,
        R_ONE = 3'b010,
        R_TWO = 3'b011,
        R_FOUR = 3'b100
    } ratio_t;

    typedef enum logic [2:0] {
        INIT_SYNC = 3'b000,
        INIT_SETTLE = 3'b001,
        INIT_LOAD = 3'b010,
        INIT_APPLY = 3'b011,
        INIT_DONE = 3'b100
    } init_t;

endpackage

// ---- ratio_decoder.sv ----
// decodes mode, loop bypass bits and ratio_select into clock multipliers
module ratio_decoder import clk_ratio_pkg::*; (
    input wire logic [2:0] mode,
    input wire logic [7:0] ratio,
    output logic legal,
    output ratio_t base,
    output ratio_t core,
    output ratio_t bus,
    output ratio_t peri
);
    logic p1_run;
    logic p2_run;
    logic [3:0] fr;

    task automatic set4(input ratio_t b, input ratio_t c, input ratio_t e, input ratio_t p);
        legal = 1'b1;
        base = b;
        core = c;
        bus = e;
        peri = p;
    endtask

    always_comb begin
        p1_run = !ratio[BIT_PLL1_BYP];
        p2_run = !ratio[BIT_PLL2_BYP];
        fr = ratio[FR_MSB:FR_LSB];
        legal = 1'b0;
        base = R_ONE;
        core = R_ONE;
        bus = R_ONE;
        peri = R_ONE;
        if (p1_run && p2_run && mode <= MODE1) begin
            case (fr)
                4'h0: set4(R_FOUR, R_ONE, R_ONE, R_ONE);
                4'h4: set4(R_FOUR, R_TWO, R_ONE, R_ONE);
                4'h5: set4(R_FOUR, R_TWO, R_TWO, R_ONE);
                4'h6: set4(R_FOUR, R_TWO, R_TWO, R_TWO);
                4'h8: set4(R_FOUR, R_FOUR, R_ONE, R_ONE);
                4'h9: set4(R_FOUR, R_FOUR, R_TWO, R_ONE);
                4'hA: set4(R_FOUR, R_FOUR, R_TWO, R_TWO);
                4'hC: set4(R_FOUR, R_FOUR, R_FOUR, R_ONE);
                4'hE: set4(R_FOUR, R_FOUR, R_FOUR, R_TWO);
                default: legal = 1'b0;
            endcase
        end else if (!p1_run && p2_run && mode <= MODE3) begin
            case (fr)
                4'h0: set4(R_ONE, R_ONE, R_ONE, R_ONE);
                4'h5: set4(R_TWO, R_TWO, R_TWO, R_ONE);
                4'h6: set4(R_TWO, R_TWO, R_TWO, R_TWO);
                4'hC: set4(R_FOUR, R_FOUR, R_FOUR, R_ONE);
                4'hE: set4(R_FOUR, R_FOUR, R_FOUR, R_TWO);
                default: legal = 1'b0;
            endcase
        end else if (p1_run && !p2_run && mode <= MODE1) begin
            case (fr)
                4'h0: set4(R_FOUR, R_ONE, R_ONE, R_ONE);
                4'h4: set4(R_FOUR, R_TWO, R_ONE, R_ONE);
                4'h8: set4(R_FOUR, R_FOUR, R_ONE, R_ONE);
                default: legal = 1'b0;
            endcase
        end else if (p1_run && (mode == MODE4 || mode == MODE5)) begin
            case (fr)
                4'h5: set4(R_TWO, R_ONE, R_ONE, R_HALF);
                4'h6: set4(R_TWO, R_ONE, R_ONE, R_ONE);
                4'h9: set4(R_TWO, R_TWO, R_ONE, R_HALF);
                4'hA: set4(R_TWO, R_TWO, R_ONE, R_ONE);
                default: legal = 1'b0;
            endcase
        end else if (!p1_run && !p2_run && mode <= MODE6) begin
            case (fr)
                4'h0: set4(R_ONE, R_QUARTER, R_QUARTER, R_QUARTER);
                4'h4: set4(R_ONE, R_HALF, R_QUARTER, R_QUARTER);
                4'h5: set4(R_ONE, R_HALF, R_HALF, R_QUARTER);
                4'h6: set4(R_ONE, R_HALF, R_HALF, R_HALF);
                4'h8: set4(R_ONE, R_ONE, R_QUARTER, R_QUARTER);
                4'h9: set4(R_ONE, R_ONE, R_HALF, R_QUARTER);
                4'hA: set4(R_ONE, R_ONE, R_HALF, R_HALF);
                4'hC: set4(R_ONE, R_ONE, R_ONE, R_QUARTER);
                4'hE: set4(R_ONE, R_ONE, R_ONE, R_HALF);
                4'hF: set4(R_ONE, R_ONE, R_ONE, R_ONE);
                default: legal = 1'b0;
            endcase
        end
    end
endmodule // ratio_decoder

// ---- settle_timer.sv ----
// loop settling counter: prescaled 8-bit count, overflow ends settling
module settle_timer import clk_ratio_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [WD_CKS_W-1:0] sel,
    output logic busy,
    output logic overflow
);
    logic [SETTLE_CNT_W-1:0] pre_reg;
    logic [SETTLE_CNT_W-1:0] pre_next;
    logic [SETTLE_CNT_W-1:0] cnt_reg;
    logic [SETTLE_CNT_W-1:0] cnt_next;
    logic [SETTLE_CNT_W-1:0] mask;
    logic busy_reg;
    logic busy_next;
    logic tick;

    always_comb begin
        mask = SETTLE_CNT_W'((9'h002 << sel) - 9'h001);
        tick = busy_reg && ((pre_reg & mask) == mask);
        overflow = tick && (cnt_reg == SETTLE_CNT_MAX);
        pre_next = pre_reg;
        cnt_next = cnt_reg;
        busy_next = busy_reg;
        if (start) begin
            pre_next = '0;
            cnt_next = '0;
            busy_next = 1'b1;
        end else if (busy_reg) begin
            pre_next = SETTLE_CNT_W'(pre_reg + 8'h01);
            if (tick) begin
                cnt_next = SETTLE_CNT_W'(cnt_reg + 8'h01);
            end
            if (overflow) begin
                busy_next = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_reg <= '0;
            cnt_reg <= '0;
            busy_reg <= 1'b0;
        end else begin
            pre_reg <= pre_next;
            cnt_reg <= cnt_next;
            busy_reg <= busy_next;
        end
    end

    assign busy = busy_reg;
endmodule // settle_timer

// ---- clock_ratio_ctrl.sv ----
// clock ratio control: ratio register, change sequence, settling and apply
// Operation
// - tristate bit floats clock pin, not with loop one in modes 0-2; pin floats in modes 3-6
// - bit 4 reserved, reads zero
// - ratio_select only takes listed codes per mode; other codes are stored but start nothing
// - both loops running: base times four table
// - loop one bypassed, loop two running table
// - loop one only, modes 0/1: core table
// - modes 4/5 loop one: base times two
// - both loops bypassed: divided clock table
// - ratio write halts device five peripheral cycles
// - write starts settling timer, overflow applies ratios
// - settling overflow raises no watchdog events
// - sequence not followed: no timer, no change
// - clock pin unstable until loops settle
// - register reset only at power-on, mode dependent
// - reset values 00,40,60,A6,E0 by mode
// - bit 7 bypasses loop two, forced modes 4-6
// - bit 6 bypasses loop one, forced modes 2,3,6
//
// The Avalon-MM register port and the register addresses were decided locally.
module clock_ratio_ctrl import clk_ratio_pkg::*; (
    input wire logic REF_CLK,
    input wire logic RESETN,
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic [2:0] CLOCK_MODE_PINS,
    input wire logic EXT_AREA_READ,
    input wire logic EXT_AREA_WRITE,
    output logic PLL1_ENABLE,
    output logic PLL2_ENABLE,
    output logic [2:0] BASE_RATIO,
    output logic [2:0] CORE_RATIO,
    output logic [2:0] BUS_RATIO,
    output logic [2:0] PERI_RATIO,
    output logic CLOCK_IO_PIN_OE,
    output logic CLOCK_IO_STABLE,
    output logic CHIP_HALT,
    output logic WDT_EVENT_MASK
);
    // mode pin inputs cross into REF_CLK through two flops
    logic [2:0] mode_s1_reg;
    logic [2:0] mode_reg;
    init_t init_reg;
    init_t init_next;
    logic [7:0] ratio_reg;
    logic [7:0] ratio_next;
    logic [7:0] wd_reg;
    logic [7:0] wd_next;
    logic armed_reg;
    logic armed_next;
    logic wait_reg;
    logic wait_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [2:0] halt_reg;
    logic [2:0] halt_next;
    logic halt_out_reg;
    logic oe_reg;
    logic oe_next;
    logic stable_reg;
    logic mask_reg;
    logic pll1_reg;
    logic pll2_reg;
    ratio_t base_reg;
    ratio_t core_reg;
    ratio_t bus_reg;
    ratio_t peri_reg;
    logic apply;
    logic req;
    logic ready;
    logic commit;
    logic wr_ratio;
    logic wr_wd;
    logic start;
    logic wd_ok;
    logic busy;
    logic ovf;
    logic legal;
    ratio_t dec_base;
    ratio_t dec_core;
    ratio_t dec_bus;
    ratio_t dec_peri;

    function automatic logic [7:0] force_bits(input logic [7:0] v, input logic [2:0] m);
        logic [7:0] r;
        r = v;
        r[BIT_RSVD] = 1'b0;
        if (m >= MODE4) begin
            r[BIT_PLL2_BYP] = 1'b1;
            r[BIT_TRIS] = 1'b1;
        end
        if (m == MODE2 || m == MODE3 || m == MODE6) begin
            r[BIT_PLL1_BYP] = 1'b1;
        end
        return r;
    endfunction

    function automatic logic [7:0] reset_value(input logic [2:0] m);
        logic [7:0] r;
        r = RST_MODE01;
        case (m)
            MODE2: r = RST_MODE2;
            MODE3: r = RST_MODE3;
            MODE4, MODE5: r = RST_MODE45;
            MODE6: r = RST_MODE6;
            default: r = RST_MODE01;
        endcase
        return r;
    endfunction

    ratio_decoder u_decoder (
        .mode(mode_reg),
        .ratio(ratio_next),
        .legal(legal),
        .base(dec_base),
        .core(dec_core),
        .bus(dec_bus),
        .peri(dec_peri)
    );

    settle_timer u_timer (
        .clk(REF_CLK),
        .rst_n(RESETN),
        .start(start),
        .sel(wd_reg[WD_CKS_LSB +: WD_CKS_W]),
        .busy(busy),
        .overflow(ovf)
    );

    // bus slave: waitrequest high for at least one cycle (longer during init or halt, and for ratio writes during settling), then low for one
    always_comb begin
        req = AVS_READ || AVS_WRITE;
        // ratio writes wait out a settling period; all access waits out the halt
        ready = (init_reg == INIT_DONE) && (halt_reg == 3'h0)
            && !(AVS_WRITE && AVS_ADDRESS == OFF_RATIO && busy);
        commit = req && !wait_reg;
        wait_next = !(req && wait_reg && ready);
        rdata_next = rdata_reg;
        if (req && wait_reg && ready) begin
            case (AVS_ADDRESS)
                OFF_RATIO: rdata_next = {24'h000000, ratio_reg};
                OFF_WDSETUP: rdata_next = {24'h000000, wd_reg};
                OFF_STATUS: rdata_next = {17'h00000, peri_reg, bus_reg, core_reg, base_reg,
                    halt_out_reg, armed_reg, busy};
                default: rdata_next = 32'h00000000;
            endcase
        end
        wr_ratio = commit && AVS_WRITE && AVS_ADDRESS == OFF_RATIO && AVS_BYTEENABLE[0];
        wr_wd = commit && AVS_WRITE && AVS_ADDRESS == OFF_WDSETUP && AVS_BYTEENABLE[0];
    end

    // change sequence and register updates
    always_comb begin
        wd_ok = !wd_reg[WD_TMODE_BIT] && !wd_reg[WD_EN_BIT];
        init_next = init_reg;
        ratio_next = ratio_reg;
        apply = 1'b0;
        unique case (init_reg)
            INIT_SYNC: init_next = INIT_SETTLE;
            INIT_SETTLE: init_next = INIT_LOAD;
            INIT_LOAD: begin
                ratio_next = force_bits(reset_value(mode_reg), mode_reg);
                init_next = INIT_APPLY;
            end
            INIT_APPLY: begin
                apply = 1'b1;
                init_next = INIT_DONE;
            end
            INIT_DONE: init_next = INIT_DONE;
            default: init_next = INIT_SYNC;
        endcase
        if (wr_ratio) begin
            ratio_next = force_bits(AVS_WRITEDATA[7:0], mode_reg);
        end
        // without the full sequence the value is stored but never switched in
        start = wr_ratio && armed_reg && wd_ok && legal;
        if (ovf) begin
            apply = 1'b1;
        end
        wd_next = wr_wd ? AVS_WRITEDATA[7:0] : wd_reg;
        // a dummy read arms; an external write or the ratio write disarms; read wins
        armed_next = armed_reg;
        if (EXT_AREA_WRITE || wr_ratio) begin
            armed_next = 1'b0;
        end
        if (EXT_AREA_READ) begin
            armed_next = 1'b1;
        end
        halt_next = halt_reg;
        if (start) begin
            halt_next = HALT_CYCLES;
        end else if (halt_reg != 3'h0) begin
            halt_next = 3'(halt_reg - 3'h1);
        end
        oe_next = mode_reg <= MODE2
            && (!ratio_reg[BIT_TRIS] || !ratio_reg[BIT_PLL1_BYP]);
    end

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            mode_s1_reg <= 3'h0;
            mode_reg <= 3'h0;
            init_reg <= INIT_SYNC;
            ratio_reg <= RST_MODE01;
            wd_reg <= WD_SETUP_RST;
            armed_reg <= 1'b0;
            wait_reg <= 1'b1;
            rdata_reg <= 32'h00000000;
            halt_reg <= 3'h0;
            halt_out_reg <= 1'b0;
            oe_reg <= 1'b0;
            stable_reg <= 1'b0;
            mask_reg <= 1'b0;
            pll1_reg <= 1'b0;
            pll2_reg <= 1'b0;
            base_reg <= R_ONE;
            core_reg <= R_ONE;
            bus_reg <= R_ONE;
            peri_reg <= R_ONE;
        end else begin
            mode_s1_reg <= CLOCK_MODE_PINS;
            mode_reg <= mode_s1_reg;
            init_reg <= init_next;
            ratio_reg <= ratio_next;
            wd_reg <= wd_next;
            armed_reg <= armed_next;
            wait_reg <= wait_next;
            rdata_reg <= rdata_next;
            halt_reg <= halt_next;
            halt_out_reg <= halt_next != 3'h0;
            oe_reg <= oe_next;
            stable_reg <= !busy && init_reg == INIT_DONE;
            mask_reg <= busy;
            if (apply) begin
                pll1_reg <= !ratio_next[BIT_PLL1_BYP];
                pll2_reg <= !ratio_next[BIT_PLL2_BYP];
                base_reg <= dec_base;
                core_reg <= dec_core;
                bus_reg <= dec_bus;
                peri_reg <= dec_peri;
            end
        end
    end

    assign AVS_READDATA = rdata_reg;
    assign AVS_WAITREQUEST = wait_reg;
    assign PLL1_ENABLE = pll1_reg;
    assign PLL2_ENABLE = pll2_reg;
    assign BASE_RATIO = base_reg;
    assign CORE_RATIO = core_reg;
    assign BUS_RATIO = bus_reg;
    assign PERI_RATIO = peri_reg;
    assign CLOCK_IO_PIN_OE = oe_reg;
    assign CLOCK_IO_STABLE = stable_reg;
    assign CHIP_HALT = halt_out_reg;
    assign WDT_EVENT_MASK = mask_reg;

    property p_rsvd_zero;
        @(posedge REF_CLK) disable iff (!RESETN)
        (AVS_READ && !AVS_WAITREQUEST && $past(AVS_ADDRESS) == OFF_RATIO)
            |-> !AVS_READDATA[BIT_RSVD];
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit read as one");

    property p_halt_len;
        @(posedge REF_CLK) disable iff (!RESETN)
        start |=> CHIP_HALT [*5] ##1 !CHIP_HALT;
    endproperty
    a_halt_len: assert property (p_halt_len) else $error("halt not five cycles");

    property p_no_start;
        @(posedge REF_CLK) disable iff (!RESETN)
        (wr_ratio && (!armed_reg || !wd_ok)) |=> !busy && !CHIP_HALT;
    endproperty
    a_no_start: assert property (p_no_start) else $error("timer started without sequence");

    property p_start_runs;
        @(posedge REF_CLK) disable iff (!RESETN)
        start |=> busy ##1 (busy && !CLOCK_IO_STABLE) ##1 !CLOCK_IO_STABLE;
    endproperty
    a_start_runs: assert property (p_start_runs) else $error("settling did not begin");

    property p_hold_ratio;
        @(posedge REF_CLK) disable iff (!RESETN)
        (init_reg == INIT_DONE && $past(init_reg) == INIT_DONE && !$past(ovf))
            |-> $stable(CORE_RATIO) && $stable(PERI_RATIO);
    endproperty
    a_hold_ratio: assert property (p_hold_ratio) else $error("ratio changed without overflow");

    property p_mask;
        @(posedge REF_CLK) disable iff (!RESETN)
        ovf |=> WDT_EVENT_MASK ##1 !WDT_EVENT_MASK;
    endproperty
    a_mask: assert property (p_mask) else $error("event mask wrong at overflow");

    property p_forced_two;
        @(posedge REF_CLK) disable iff (!RESETN)
        (init_reg == INIT_DONE && mode_reg >= MODE4)
            |-> ratio_reg[BIT_PLL2_BYP] && ratio_reg[BIT_TRIS];
    endproperty
    a_forced_two: assert property (p_forced_two) else $error("loop two bit not forced");

    property p_forced_one;
        @(posedge REF_CLK) disable iff (!RESETN)
        (init_reg == INIT_DONE && (mode_reg == MODE2 || mode_reg == MODE3 || mode_reg == MODE6))
            |-> ratio_reg[BIT_PLL1_BYP];
    endproperty
    a_forced_one: assert property (p_forced_one) else $error("loop one bit not forced");

    property p_pin_drive;
        @(posedge REF_CLK) disable iff (!RESETN)
        (mode_reg <= MODE2 && !ratio_reg[BIT_PLL1_BYP] && $stable(mode_reg))
            |=> CLOCK_IO_PIN_OE;
    endproperty
    a_pin_drive: assert property (p_pin_drive) else $error("pin floated with loop one");

endmodule // clock_ratio_ctrl

// ---- ext_side_model.sv ----
// external bus side model: dummy read and external write strobes
module ext_side_model (
    input wire logic REF_CLK,
    output logic EXT_AREA_READ,
    output logic EXT_AREA_WRITE
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        EXT_AREA_READ = 1'b0;
        EXT_AREA_WRITE = 1'b0;
    end

    // one-cycle read of the uncached external window, before the ratio write
    task automatic dummy_read();
        @(posedge REF_CLK);
        EXT_AREA_READ <= 1'b1;
        @(posedge REF_CLK);
        EXT_AREA_READ <= 1'b0;
    endtask

    // external writes happen only when the bench commands one
    task automatic ext_write();
        @(posedge REF_CLK);
        EXT_AREA_WRITE <= 1'b1;
        @(posedge REF_CLK);
        EXT_AREA_WRITE <= 1'b0;
    endtask
endmodule // ext_side_model

// ---- tb.sv ----
// self-checking testbench for the clock ratio control block
`define CHK(a, b) check_val(32'(a), 32'(b))
module tb import clk_ratio_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic rd = 1'b0;
    logic wr_en = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic [2:0] mode = 3'h0;
    logic [31:0] rdata, got;
    logic waitreq, pll1, pll2, oe, stable, halt, mask, ext_rd, ext_wr;
    logic [2:0] base_r, core_r, bus_r, peri_r;
    int fail_count = 0;
    int compares = 0;
    int halt_cnt = 0;
    wire logic [15:0] ratios = {1'b0, base_r, 1'b0, core_r, 1'b0, bus_r, 1'b0, peri_r};
    wire logic [2:0] pins = {oe, pll1, pll2};

    always #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (halt === 1'b1) halt_cnt <= halt_cnt + 1;

    clock_ratio_ctrl u_clock_ratio_ctrl (
        .REF_CLK(ref_clk), .RESETN(resetn), .AVS_ADDRESS(addr), .AVS_READ(rd),
        .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF),
        .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq), .CLOCK_MODE_PINS(mode),
        .EXT_AREA_READ(ext_rd), .EXT_AREA_WRITE(ext_wr), .PLL1_ENABLE(pll1),
        .PLL2_ENABLE(pll2), .BASE_RATIO(base_r), .CORE_RATIO(core_r), .BUS_RATIO(bus_r),
        .PERI_RATIO(peri_r), .CLOCK_IO_PIN_OE(oe), .CLOCK_IO_STABLE(stable),
        .CHIP_HALT(halt), .WDT_EVENT_MASK(mask)
    );
    ext_side_model u_ext_side_model (.REF_CLK(ref_clk), .EXT_AREA_READ(ext_rd),
        .EXT_AREA_WRITE(ext_wr));

    task automatic check_val(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic stop_test();
        $display("fail_count=%0d compares=%0d", fail_count, compares);
        if (fail_count == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic do_reset(input logic [2:0] m);
        resetn <= 1'b0;
        mode <= m;
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (8) @(posedge ref_clk);
    endtask

    // one access, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        int n;
        logic timed_out;
        n = 0;
        addr <= a;
        wdata <= {24'h0, d};
        if (w) wr_en <= 1'b1;
        else rd <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (waitreq !== 1'b0 && n < 3000);
        timed_out = waitreq !== 1'b0;
        got = rdata;
        wr_en <= 1'b0;
        rd <= 1'b0;
        @(posedge ref_clk);
        if (timed_out) begin
            fail_count++;
            stop_test();
        end
    endtask

    // full change sequence, then the applied ratios and pin states
    task automatic change(input logic [7:0] v, input logic [15:0] r, input logic [2:0] p);
        int h0;
        int n;
        logic [15:0] r0;
        bus(1'b1, OFF_WDSETUP, 8'h00);
        u_ext_side_model.dummy_read();
        r0 = ratios;
        h0 = halt_cnt;
        bus(1'b1, OFF_RATIO, v);
        // read back right after the write, answered once the halt ends
        bus(1'b0, OFF_RATIO, 8'h00);
        `CHK(got, v);
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk);
        `CHK(halt_cnt - h0, 5);
        `CHK(mask, 1'b1);
        repeat (385) @(negedge ref_clk);
        `CHK(stable, 1'b0);
        `CHK(ratios, r0);
        n = 0;
        while (stable !== 1'b1 && n < 2000) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 2000) begin
            fail_count++;
            stop_test();
        end
        repeat (3) @(negedge ref_clk);
        `CHK(ratios, r);
        `CHK(pins, p);
        @(posedge ref_clk);
    endtask

    // ratio write that must start nothing
    task automatic refuse(input logic [7:0] wd, input logic arm, input logic ext,
                          input logic [7:0] v);
        int h0;
        logic [15:0] r0;
        r0 = ratios;
        bus(1'b1, OFF_WDSETUP, wd);
        if (arm) u_ext_side_model.dummy_read();
        if (ext) u_ext_side_model.ext_write();
        h0 = halt_cnt;
        bus(1'b1, OFF_RATIO, v);
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk);
        `CHK(halt_cnt - h0, 0);
        `CHK(ratios, r0);
        `CHK(stable, 1'b1);
        @(posedge ref_clk);
    endtask

    task automatic t_reset_values();
        logic [7:0] rv [7];
        rv = '{8'h00, 8'h00, 8'h40, 8'h60, 8'hA6, 8'hA6, 8'hE0};
        for (int m = 0; m < 7; m++) begin
            do_reset(3'(m));
            bus(1'b0, OFF_RATIO, 8'h00);
            `CHK(got, rv[m]);
        end
        bus(1'b1, OFF_RATIO, 8'h1F);
        bus(1'b0, OFF_RATIO, 8'h00);
        `CHK(got, 8'hEF);
    endtask

    task automatic t_mode4();
        do_reset(3'h4);
        `CHK(ratios, 16'h3222);
        `CHK(pins, 3'b010);
        change(8'hA9, 16'h3321, 3'b010);
    endtask

    task automatic t_mode0();
        do_reset(3'h0);
        `CHK(ratios, 16'h4222);
        bus(1'b1, 4'hC, 8'h5A);
        bus(1'b0, 4'hC, 8'h00);
        `CHK(got, 0);
        refuse(8'h80, 1'b1, 1'b0, 8'h0A);
        refuse(8'h20, 1'b1, 1'b0, 8'h0A);
        refuse(8'h00, 1'b1, 1'b1, 8'h0A);
        refuse(8'h00, 1'b1, 1'b0, 8'h03);
        refuse(8'h00, 1'b0, 1'b0, 8'h1F);
        bus(1'b0, OFF_RATIO, 8'h00);
        `CHK(got, 8'h0F);
        change(8'h0A, 16'h4433, 3'b111);
        change(8'h45, 16'h3332, 3'b101);
        change(8'h88, 16'h4422, 3'b110);
        change(8'hCC, 16'h2220, 3'b100);
        change(8'hE0, 16'h2000, 3'b000);
        change(8'h20, 16'h4222, 3'b111);
    endtask

    initial begin
        t_reset_values();
        t_mode4();
        t_mode0();
        stop_test();
    end
endmodule // tb
